// [twrf_formatter.sv]
// Functional notes
// - pulse header: tag 10, four zeros, two-bit index, ten-bit sample number
// - pulse indices run 00..11 in order; at most four pulses per record
// - sample words tagged 00 follow their header, first to last
// - after the last sample, an end word tagged 11 with sixteen zero bits
// - no-event record: word 0 tag 00 type 10010 trigger 26-16, word 1 bits 15-0
// - no-event words 2-5 carry stamp msb first; last two words tagged 01
// - next pulse section follows prior pulse's last sample directly
// - first pulse section uses index 00
`timescale 1ns/1ns
module twrf_formatter (
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // window start: event record or no-event record
  input  wire logic                   startEvent,
  input  wire logic                   startNoEvent,
  input  wire logic [26:0]            trigNum,
  input  wire logic [47:0]            timeStamp,
  output logic                        startReady,
  // pulse stream
  input  wire logic                   pulseValid,
  input  wire logic [9:0]             pulseSampleNum,
  output logic                        pulseReady,
  input  wire logic                   sampleValid,
  input  wire logic [15:0]            sampleData,
  input  wire logic                   sampleLast,
  input  wire logic                   windowDone,
  output logic                        sampleReady,
  // toward readout fifo
  output logic                        fifoValid,
  input  wire logic                   fifoReady,
  output twrf_pkg::twrf_word_type     fifoWord
);

  // ------------------------------------------------------------
  // framing state
  // ------------------------------------------------------------
  twrf_pkg::twrf_state_type state_q, state_d;
  logic [1:0]              pidx_q, pidx_d;
  logic                    morePulse_q, morePulse_d;
  logic [2:0]              loc_q, loc_d;
  logic [26:0]             trig_q, trig_d;
  logic [47:0]             stamp_q, stamp_d;
  logic                    rdy_q, rdy_d;
  logic                    wValid;
  twrf_pkg::twrf_word_type wWord;
  logic                    bufReady;

  // no-event word for a location
  function automatic twrf_pkg::twrf_word_type noevtWord(input logic [2:0] loc,
      input logic [26:0] tn, input logic [47:0] ts);
    twrf_pkg::twrf_word_type w;
    w = '0;
    unique case (loc)
      3'h0: w = {twrf_pkg::TAG_DATA, twrf_pkg::TYPE_NOEVT,
                 tn[twrf_pkg::TRIG_HI_TOP:twrf_pkg::TRIG_HI_BOT]};
      3'h1: w = {twrf_pkg::TAG_DATA, tn[twrf_pkg::TRIG_LO_TOP:0]};
      3'h2: w = {twrf_pkg::TAG_DATA, 8'h00,
                 ts[twrf_pkg::ST_A_TOP:twrf_pkg::ST_A_BOT]};
      3'h3: w = {twrf_pkg::TAG_DATA, ts[twrf_pkg::ST_B_TOP:twrf_pkg::ST_B_BOT]};
      3'h4: w = {twrf_pkg::TAG_STAMP, 8'h00,
                 ts[twrf_pkg::ST_C_TOP:twrf_pkg::ST_C_BOT]};
      default: w = {twrf_pkg::TAG_STAMP, ts[twrf_pkg::ST_D_TOP:0]};
    endcase
    return w;
  endfunction

  always_comb begin
    state_d     = state_q;
    pidx_d      = pidx_q;
    morePulse_d = morePulse_q;
    loc_d       = loc_q;
    trig_d      = trig_q;
    stamp_d     = stamp_q;
    wValid      = 1'b0;
    wWord       = '0;
    pulseReady  = 1'b0;
    sampleReady = 1'b0;
    unique case (state_q)
      twrf_pkg::ST_IDLE: begin
        if (startNoEvent) begin
          trig_d  = trigNum;
          stamp_d = timeStamp;
          loc_d   = 3'h0;
          state_d = twrf_pkg::ST_NOEVT;
        end else if (startEvent) begin
          pidx_d      = twrf_pkg::PIDX_FIRST;
          morePulse_d = 1'b1;
          state_d     = twrf_pkg::ST_HEADER;
        end
      end
      twrf_pkg::ST_HEADER: begin
        if (windowDone || !morePulse_q) begin
          state_d = twrf_pkg::ST_END;
        end else begin
          wValid     = pulseValid;
          pulseReady = bufReady;
          wWord      = {twrf_pkg::TAG_HEADER, twrf_pkg::PAD_ZERO, pidx_q,
                        pulseSampleNum};
          if (pulseValid && bufReady) begin
            state_d = twrf_pkg::ST_DATA;
          end
        end
      end
      twrf_pkg::ST_DATA: begin
        wValid      = sampleValid;
        sampleReady = bufReady;
        wWord       = {twrf_pkg::TAG_DATA, sampleData};
        if (sampleValid && bufReady && sampleLast) begin
          morePulse_d = (pidx_q != twrf_pkg::PIDX_LAST);
          pidx_d      = pidx_q + 2'h1;
          state_d     = twrf_pkg::ST_HEADER;
        end
      end
      twrf_pkg::ST_END: begin
        wValid = 1'b1;
        wWord  = {twrf_pkg::TAG_END, twrf_pkg::PAD_ZERO, 12'h000};
        if (bufReady) begin
          state_d = twrf_pkg::ST_IDLE;
        end
      end
      twrf_pkg::ST_NOEVT: begin
        wValid = 1'b1;
        wWord  = noevtWord(loc_q, trig_q, stamp_q);
        if (bufReady) begin
          loc_d = loc_q + 3'h1;
          if (loc_q == twrf_pkg::NOEVT_LAST) begin
            state_d = twrf_pkg::ST_IDLE;
          end
        end
      end
      default: state_d = twrf_pkg::ST_IDLE;
    endcase
    rdy_d = (state_d == twrf_pkg::ST_IDLE);
  end

  assign startReady = rdy_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q     <= twrf_pkg::ST_IDLE;
      pidx_q      <= 2'h0;
      morePulse_q <= 1'b0;
      loc_q       <= 3'h0;
      trig_q      <= '0;
      stamp_q     <= '0;
      rdy_q       <= 1'b1;
    end else begin
      state_q     <= state_d;
      pidx_q      <= pidx_d;
      morePulse_q <= morePulse_d;
      loc_q       <= loc_d;
      trig_q      <= trig_d;
      stamp_q     <= stamp_d;
      rdy_q       <= rdy_d;
    end
  end

  // ------------------------------------------------------------
  // output buffer; fifo outputs come from its storage flops
  // ------------------------------------------------------------
  twrf_skid u_skid (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .inValid  (wValid),
    .inReady  (bufReady),
    .inWord   (wWord),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outWord  (fifoWord)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_hdr_fmt;
    @(posedge clk_sys) disable iff (!nrst)
      (fifoValid && fifoWord.tag == twrf_pkg::TAG_HEADER)
        |-> fifoWord.payload[15:12] == twrf_pkg::PAD_ZERO;
  endproperty
  a_hdr_fmt: assert property (p_hdr_fmt) else $error("header pad not zero");

  property p_idx_step;
    @(posedge clk_sys) disable iff (!nrst)
      (state_q == twrf_pkg::ST_DATA && sampleValid && bufReady && sampleLast)
        |=> pidx_q == $past(pidx_q) + 2'h1;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("pulse index skipped");

  property p_four_max;
    @(posedge clk_sys) disable iff (!nrst)
      (state_q == twrf_pkg::ST_HEADER && !morePulse_q) |-> !pulseReady;
  endproperty
  a_four_max: assert property (p_four_max) else $error("fifth pulse taken");

  property p_data_tag;
    @(posedge clk_sys) disable iff (!nrst)
      (state_q == twrf_pkg::ST_DATA && wValid) |-> wWord.tag == twrf_pkg::TAG_DATA;
  endproperty
  a_data_tag: assert property (p_data_tag) else $error("sample tag wrong");

  property p_end_word;
    @(posedge clk_sys) disable iff (!nrst)
      (state_q == twrf_pkg::ST_END && bufReady) |=> state_q == twrf_pkg::ST_IDLE;
  endproperty
  a_end_word: assert property (p_end_word) else $error("end word not closing");

  sequence s_noevt_start;
    state_q == twrf_pkg::ST_IDLE && startNoEvent;
  endsequence
  property p_noevt_first;
    @(posedge clk_sys) disable iff (!nrst)
      s_noevt_start |=> wWord.payload[15:11] == twrf_pkg::TYPE_NOEVT && wValid;
  endproperty
  a_noevt_first: assert property (p_noevt_first) else $error("no-event type bad");

  property p_noevt_tag;
    @(posedge clk_sys) disable iff (!nrst)
      (state_q == twrf_pkg::ST_NOEVT && loc_q >= 3'h4) |-> wWord.tag == twrf_pkg::TAG_STAMP;
  endproperty
  a_noevt_tag: assert property (p_noevt_tag) else $error("stamp tag wrong");

  property p_first_idx;
    @(posedge clk_sys) disable iff (!nrst)
      (state_q == twrf_pkg::ST_IDLE && startEvent && !startNoEvent) |=> pidx_q == 2'h0;
  endproperty
  a_first_idx: assert property (p_first_idx) else $error("first index not 00");

  property p_next_hdr;
    @(posedge clk_sys) disable iff (!nrst)
      (state_q == twrf_pkg::ST_DATA && sampleValid && bufReady && sampleLast)
        |=> state_q == twrf_pkg::ST_HEADER;
  endproperty
  a_next_hdr: assert property (p_next_hdr) else $error("section not adjacent");

endmodule // twrf_formatter

// [twrf_pkg.sv]
package twrf_pkg;

  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int TAG_W   = 2;
  localparam int PAY_W   = 16;
  localparam int WORD_W  = TAG_W + PAY_W;
  localparam int SNUM_W  = 10;
  localparam int PIDX_W  = 2;
  localparam int TRIG_W  = 27;
  localparam int STAMP_W = 48;
  localparam int NPULSE  = 4;

  localparam logic [1:0] TAG_DATA   = 2'h0;
  localparam logic [1:0] TAG_STAMP  = 2'h1;
  localparam logic [1:0] TAG_HEADER = 2'h2;
  localparam logic [1:0] TAG_END    = 2'h3;

  localparam logic [3:0] PAD_ZERO   = 4'h0;
  localparam logic [4:0] TYPE_NOEVT = 5'h12;
  localparam logic [1:0] PIDX_FIRST = 2'h0;
  localparam logic [1:0] PIDX_LAST  = 2'h3;

  // field positions
  localparam int TRIG_HI_TOP = 26;
  localparam int TRIG_HI_BOT = 16;
  localparam int TRIG_LO_TOP = 15;
  localparam int ST_A_TOP    = 47;
  localparam int ST_A_BOT    = 40;
  localparam int ST_B_TOP    = 39;
  localparam int ST_B_BOT    = 24;
  localparam int ST_C_TOP    = 23;
  localparam int ST_C_BOT    = 16;
  localparam int ST_D_TOP    = 15;

  // no-event record length, locations 0..5
  localparam logic [2:0] NOEVT_LAST = 3'h5;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [PAY_W-1:0] payload;
  } twrf_word_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HEADER = 3'b001,
    ST_DATA   = 3'b010,
    ST_END    = 3'b011,
    ST_NOEVT  = 3'b100
  } twrf_state_type;

endpackage

// [twrf_skid.sv]
`timescale 1ns/1ns
module twrf_skid (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  inValid,
  output logic                       inReady,
  input  wire twrf_pkg::twrf_word_type inWord,
  output logic                       outValid,
  input  wire logic                  outReady,
  output twrf_pkg::twrf_word_type    outWord
);

  // ------------------------------------------------------------
  // two-entry buffer, registered ready so a stall loses no word
  // ------------------------------------------------------------
  twrf_pkg::twrf_word_type mem_q [2];
  twrf_pkg::twrf_word_type mem_d [2];
  logic                    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [1:0]              cnt_q, cnt_d;
  logic                    push, pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outWord  = mem_q[rdPtr_q];

  always_comb begin
    mem_d   = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (push) begin
      mem_d[wrPtr_q] = inWord;
      wrPtr_d        = ~wrPtr_q;
    end
    if (pop) begin
      rdPtr_d = ~rdPtr_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wrPtr_q  <= 1'b0;
      rdPtr_q  <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q    <= mem_d;
      wrPtr_q  <= wrPtr_d;
      rdPtr_q  <= rdPtr_d;
      cnt_q    <= cnt_d;
    end
  end

endmodule // twrf_skid

// [twrf_fifo_model.sv]
`timescale 1ns/1ns
module twrf_fifo_model (
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    slowMode,
  input  wire logic                    fifoValid,
  input  wire twrf_pkg::twrf_word_type fifoWord,
  output logic                         fifoReady
);
  // ------------------------------------------------------------
  // readout side: takes one word per clock while it has space
  // ------------------------------------------------------------
  twrf_pkg::twrf_word_type got[$];

  // slow mode gives space only every other cycle, so the buffer must hold words
  always @(posedge clk_sys) begin
    fifoReady <= nrst && !(slowMode && fifoReady);
    if (nrst && fifoValid && fifoReady) begin
      got.push_back(fifoWord);
    end
  end
endmodule // twrf_fifo_model

// [twrf_formatter_bench.sv]
`timescale 1ns/1ns
module twrf_formatter_bench;
  // ------------------------------------------------------------
  // stimulus and wiring
  // ------------------------------------------------------------
  logic                    clk_sys        = 1'b0;
  logic                    nrst           = 1'b0;
  logic                    startEvent     = 1'b0;
  logic                    startNoEvent   = 1'b0;
  logic [26:0]             trigNum        = 27'h0;
  logic [47:0]             timeStamp      = 48'h0;
  logic                    pulseValid     = 1'b0;
  logic [9:0]              pulseSampleNum = 10'h0;
  logic                    sampleValid    = 1'b0;
  logic [15:0]             sampleData     = 16'h0;
  logic                    sampleLast     = 1'b0;
  logic                    windowDone     = 1'b0;
  logic                    slowMode       = 1'b0;
  logic                    startReady;
  logic                    pulseReady;
  logic                    sampleReady;
  logic                    fifoValid;
  logic                    fifoReady;
  twrf_pkg::twrf_word_type fifoWord;
  logic [17:0]             expq[$];
  int                      badCount       = 0;
  int                      totalChecks    = 0;

  always #4 clk_sys = ~clk_sys;

  twrf_formatter i_twrf_formatter (.clk_sys(clk_sys), .nrst(nrst), .startEvent(startEvent),
    .startNoEvent(startNoEvent), .trigNum(trigNum), .timeStamp(timeStamp),
    .startReady(startReady), .pulseValid(pulseValid), .pulseSampleNum(pulseSampleNum),
    .pulseReady(pulseReady), .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleLast(sampleLast), .windowDone(windowDone), .sampleReady(sampleReady),
    .fifoValid(fifoValid), .fifoReady(fifoReady), .fifoWord(fifoWord));

  twrf_fifo_model i_twrf_fifo_model (.clk_sys(clk_sys), .nrst(nrst), .slowMode(slowMode),
    .fifoValid(fifoValid), .fifoWord(fifoWord), .fifoReady(fifoReady));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ready is looked at mid-cycle, the transfer happens at the next rising edge
  task automatic handshake(input int which);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 300 && hit !== 1'b1; k++) begin
      @(negedge clk_sys);
      hit = (which == 0) ? pulseReady : (which == 1) ? sampleReady : startReady;
    end
    check(18'(hit), 18'h00001);
    @(posedge clk_sys);
  endtask

  task automatic send_pulse(input logic [1:0] idx, input logic [9:0] sn, input int n,
                            input logic [15:0] base);
    pulseSampleNum <= sn;
    pulseValid <= 1'b1;
    handshake(0);
    pulseValid <= 1'b0;
    expq.push_back({twrf_pkg::TAG_HEADER, twrf_pkg::PAD_ZERO, idx, sn});
    for (int i = 0; i < n; i++) begin
      sampleData <= base + 16'(i);
      sampleLast <= (i == n - 1);
      sampleValid <= 1'b1;
      handshake(1);
      expq.push_back({twrf_pkg::TAG_DATA, base + 16'(i)});
    end
    sampleValid <= 1'b0;
    sampleLast <= 1'b0;
  endtask

  // waits for the record, then a few cycles more so surplus words show up
  task automatic compare_record();
    for (int k = 0; k < 500 && i_twrf_fifo_model.got.size() < expq.size(); k++) begin
      @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    check(18'(i_twrf_fifo_model.got.size()), 18'(expq.size()));
    while (expq.size() > 0 && i_twrf_fifo_model.got.size() > 0) begin
      check(i_twrf_fifo_model.got.pop_front(), expq.pop_front());
    end
    expq.delete();
    i_twrf_fifo_model.got.delete();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic run_event(input int npulse, input logic slow);
    slowMode <= slow;
    startEvent <= 1'b1;
    handshake(2);
    startEvent <= 1'b0;
    // a start while busy must be ignored
    startNoEvent <= 1'b1;
    @(posedge clk_sys);
    startNoEvent <= 1'b0;
    for (int p = 0; p < npulse; p++) begin
      send_pulse(2'(p), (p == 3) ? 10'h3FF : 10'(p * 5), p + 1, 16'(16'h1A00 * (p + 1)));
    end
    // with four pulses the record must close by itself and refuse a fifth header
    windowDone <= (npulse < 4);
    pulseValid <= (npulse >= 4);
    handshake(2);
    windowDone <= 1'b0;
    pulseValid <= 1'b0;
    expq.push_back({twrf_pkg::TAG_END, 16'h0000});
    compare_record();
  endtask

  task automatic run_noevent(input logic [26:0] tn, input logic [47:0] ts, input logic both);
    trigNum <= tn;
    timeStamp <= ts;
    startNoEvent <= 1'b1;
    startEvent <= both;
    handshake(2);
    startNoEvent <= 1'b0;
    startEvent <= 1'b0;
    expq.push_back({twrf_pkg::TAG_DATA, twrf_pkg::TYPE_NOEVT, tn[26:16]});
    expq.push_back({twrf_pkg::TAG_DATA, tn[15:0]});
    expq.push_back({twrf_pkg::TAG_DATA, 8'h00, ts[47:40]});
    expq.push_back({twrf_pkg::TAG_DATA, ts[39:24]});
    expq.push_back({twrf_pkg::TAG_STAMP, 8'h00, ts[23:16]});
    expq.push_back({twrf_pkg::TAG_STAMP, ts[15:0]});
    compare_record();
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    badCount++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    run_event(1, 1'b0);
    run_event(4, 1'b1);
    run_event(3, 1'b0);
    run_noevent(27'h5ABCDEF, 48'hFEDCBA987654, 1'b1);
    run_noevent(27'h0000001, 48'h800000000001, 1'b0);
    complete_run();
  end
endmodule // twrf_formatter_bench
